//--- rcf_reset_char.sv
// top: reset-response mode register, ctrl-c reset, locked-rotor fault
`include "rcf_cfg.svh"
module rcf_reset_char
  import rcf_pkg::*;
(
  input  wire logic        sys_clk_in,                 // 100 MHz clock
  input  wire logic        reset_n_in,                 // async, low
  input  wire logic        rx_valid_in,                // byte strobe
  input  wire logic [7:0]  rx_data_in,                 // received byte
  input  wire logic        party_addressing_select_in, // party mode on
  input  wire logic        unit_addressed_in,          // unit_name hit
  input  wire logic        reg_wr_in,                  // register write
  input  wire logic        reg_rd_in,                  // register read
  input  wire logic [15:0] reg_addr_in,                // register offset
  input  wire logic [31:0] reg_wdata_in,               // write data
  input  wire logic        rotor_lock_detect_in,       // lock event
  input  wire logic        attention_output_mask_in,   // lock -> attn
  output logic      [31:0] reg_rdata_out,              // read data
  output logic             reg_ack_out,                // access answer
  output logic             mode_range_err_out,         // bad mode write
  output logic             soft_reset_out,             // soft reset
  output logic             motion_stop_out,            // stop motion
  output logic             program_halt_out,           // halt program
  output logic             user_data_discard_out,      // drop user data
  output logic             locked_rotor_flag_out,      // fault flag
  output logic      [7:0]  error_code_out,             // error code
  output logic             attention_out,              // attention
  output logic             bridge_enable_out           // stage allowed
);

  rcf_top_s   st;       // registered state
  rcf_top_s   next_st;  // next state
  rcf_char_if char_if (); // carrier to the detector

  logic wr_mode;   // write to the mode register
  logic rd_mode;   // read of the mode register
  logic wr_clear;  // locked-rotor clear command
  logic mode_ok;   // written mode value in range

  // hand the byte stream and mode to the detector; all same clock
  assign char_if.char_valid = rx_valid_in;
  assign char_if.char_data  = rx_data_in;
  assign char_if.mode       = st.mode;
  assign char_if.party      = party_addressing_select_in;
  assign char_if.addressed  = unit_addressed_in;

  // ctrl-c detector
  rcf_ctrlc_det u_det (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .char_if    (char_if)
  );

  // address decode for the two documented offsets
  assign wr_mode  = reg_wr_in && (reg_addr_in == `RCF_MODE_OFS);
  assign rd_mode  = reg_rd_in && !reg_wr_in
                    && (reg_addr_in == `RCF_MODE_OFS);
  assign wr_clear = reg_wr_in && (reg_addr_in == `RCF_CLEAR_OFS);
  assign mode_ok  = (reg_wdata_in <= `RCF_MODE_MAX);

  // next-state logic for registers, fault latch and reset pulse
  always_comb begin
    next_st = st;
    // answers and pulses last a single cycle
    next_st.ack       = reg_wr_in || reg_rd_in;
    next_st.rdata     = '0;
    next_st.range_err = 1'b0;
    next_st.soft_rst  = char_if.reset_req;

    // mode write: out-of-range values are refused, old value kept
    if (wr_mode) begin
      if (mode_ok) begin
        next_st.mode = rcf_mode_e'(reg_wdata_in[`RCF_MODE_W-1:0]);
      end else begin
        next_st.range_err = 1'b1;
      end
    end

    // mode read-back; the clear command is write-only, reads zero
    if (rd_mode) begin
      next_st.rdata = {30'h0, st.mode};
    end

    // clear command drops the fault; a lock in the same cycle wins
    if (wr_clear) begin
      next_st.rotor_fault = 1'b0;
      next_st.err_code = `RCF_ERR_NONE;
      next_st.attn     = 1'b0;
    end

    // lock event sets the flag and code, attention only if masked in
    if (rotor_lock_detect_in) begin
      next_st.rotor_fault = 1'b1;
      next_st.err_code = `RCF_ERR_LOCK;
      if (attention_output_mask_in) begin
        next_st.attn = 1'b1;
      end
    end

    // output stage runs only while no locked-rotor fault is latched
    next_st.bridge_en = !next_st.rotor_fault;
  end

  // state register; the fault survives a soft reset, only power or the clear command clears it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st           <= '0;
      st.mode      <= rcf_mode_e'(`RCF_MODE_RESET);
      st.bridge_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out         = st.rdata;
  assign reg_ack_out           = st.ack;
  assign mode_range_err_out    = st.range_err;
  // one flop drives all reset effects so they never drift apart
  assign soft_reset_out        = st.soft_rst;
  assign motion_stop_out       = st.soft_rst;
  assign program_halt_out      = st.soft_rst;
  assign user_data_discard_out = st.soft_rst;
  assign locked_rotor_flag_out = st.rotor_fault;
  assign error_code_out        = st.err_code;
  assign attention_out         = st.attn;
  assign bridge_enable_out     = st.bridge_en;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // named steps of the clear, write and lock sequences
  sequence s_clear_cmd;
    reg_wr_in && reg_addr_in == `RCF_CLEAR_OFS && !rotor_lock_detect_in;
  endsequence
  sequence s_bad_mode;
    reg_wr_in && reg_addr_in == `RCF_MODE_OFS
      && reg_wdata_in > `RCF_MODE_MAX;
  endsequence
  sequence s_good_mode;
    reg_wr_in && reg_addr_in == `RCF_MODE_OFS
      && reg_wdata_in <= `RCF_MODE_MAX;
  endsequence
  // any register access, read or write
  sequence s_access;
    reg_wr_in || reg_rd_in;
  endsequence
  // lock event and clear command in the same cycle
  sequence s_lock_and_clear;
    rotor_lock_detect_in && wr_clear;
  endsequence

  // the four reset effects come from one flop and rise together
  reset_effects_a: assert property (
    char_if.reset_req |=> soft_reset_out && motion_stop_out
      && program_halt_out && user_data_discard_out)
    else $error("soft reset effects missing");
  // a soft reset leaves the configured mode alone
  keep_mode_a: assert property (
    soft_reset_out && !wr_mode |=> $stable(st.mode))
    else $error("soft reset disturbed the mode");
  // refused values leave the old mode in place
  range_hold_a: assert property (
    s_bad_mode |=> mode_range_err_out && $stable(st.mode))
    else $error("out-of-range mode accepted");
  // accepted values are stored and answered without a refusal
  range_take_a: assert property (
    s_good_mode |=> st.mode == $past(reg_wdata_in[1:0])
      && reg_ack_out && !mode_range_err_out)
    else $error("valid mode write not stored");
  // code 3 can never reach the mode register
  mode_legal_a: assert property (
    st.mode inside {RCF_OFF, RCF_ON, RCF_PARTY})
    else $error("illegal mode stored");
  // read-back shows the mode in the low bits, zeros above
  mode_read_a: assert property (
    rd_mode |=> reg_ack_out && reg_rdata_out[31:2] == 30'h0
      && reg_rdata_out[1:0] == $past(st.mode))
    else $error("mode read-back wrong");
  // read data is zero whenever no mode read was answered
  rdata_idle_a: assert property (
    !rd_mode |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a mode read");
  // every access gets exactly one answer, a cycle later
  ack_pulse_a: assert property (
    s_access |=> reg_ack_out)
    else $error("access not answered");
  ack_quiet_a: assert property (
    !(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
    else $error("answer without an access");
  // a refusal only ever comes with an answer
  err_with_ack_a: assert property (
    mode_range_err_out |-> reg_ack_out)
    else $error("refusal without an answer");
  // a lock latches flag and code and stops the output stage
  lock_flag_a: assert property (
    rotor_lock_detect_in |=> locked_rotor_flag_out
      && error_code_out == `RCF_ERR_LOCK && !bridge_enable_out)
    else $error("lock did not latch flag and code");
  attn_latch_a: assert property (
    rotor_lock_detect_in && attention_output_mask_in
      |=> attention_out)
    else $error("masked-in lock did not latch attention");
  // latched indications hold until a clear command arrives
  flag_hold_a: assert property (
    locked_rotor_flag_out && !wr_clear |=> locked_rotor_flag_out)
    else $error("fault flag dropped without a clear");
  attn_hold_a: assert property (
    attention_out && !wr_clear |=> attention_out)
    else $error("attention dropped without a clear");
  // the error code always follows the fault flag
  code_track_a: assert property (
    error_code_out == (locked_rotor_flag_out ? `RCF_ERR_LOCK
                                             : `RCF_ERR_NONE))
    else $error("error code disagrees with the fault flag");
  // a clear with no lock beside it drops every indication
  fault_clear_a: assert property (
    s_clear_cmd |=> !locked_rotor_flag_out && bridge_enable_out
      && error_code_out == `RCF_ERR_NONE && !attention_out)
    else $error("clear command did not drop the fault");
  // a lock in the clear cycle keeps the fault latched
  lock_wins_a: assert property (
    s_lock_and_clear |=> locked_rotor_flag_out && !bridge_enable_out)
    else $error("clear overrode a simultaneous lock");
  // output stage is held off exactly while the fault is latched
  bridge_track_a: assert property (
    bridge_enable_out == !locked_rotor_flag_out)
    else $error("output stage enable disagrees with the fault");

endmodule : rcf_reset_char

//--- rcf_cfg.svh
// offsets, field values, reset values and codes for the reset-char block
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

// register offsets on the command register port
`define RCF_MODE_OFS   16'h0009
`define RCF_CLEAR_OFS  16'h0093

// reset-response mode values and limits
`define RCF_MODE_RESET 2'h1
`define RCF_MODE_MAX   32'h0000_0002
`define RCF_MODE_W     2

// serial control character and fault code
`define RCF_CTRL_C     8'h03
`define RCF_ERR_LOCK   8'h68
`define RCF_ERR_NONE   8'h00

`endif

//--- rcf_pkg.sv
// types shared by the reset-char and locked-rotor clear block
package rcf_pkg;
  // reset-response mode as stored in the configuration register
  typedef enum logic [1:0] {
    RCF_OFF   = 2'h0,  // ctrl-c ignored
    RCF_ON    = 2'h1,  // ctrl-c resets
    RCF_PARTY = 2'h2   // ctrl-c resets; with party mode on, only when addressed
  } rcf_mode_e;

  // state of the ctrl-c detector
  typedef struct packed {
    logic reset_req;  // one-cycle request toward the top
  } rcf_det_s;

  // state of the top module
  typedef struct packed {
    rcf_mode_e   mode;        // reset-response mode
    logic        rotor_fault; // latched locked-rotor flag
    logic [7:0]  err_code;    // current error code
    logic        attn;        // latched attention output
    logic        bridge_en;   // output stage allowed to run
    logic        soft_rst;    // soft reset pulse
    logic [31:0] rdata;       // register read data
    logic        ack;         // register access answer
    logic        range_err;   // out-of-range mode write
  } rcf_top_s;
endpackage : rcf_pkg

//--- rcf_char_if.sv
// carrier between the top and the ctrl-c detector
interface rcf_char_if;
  import rcf_pkg::*;
  logic       char_valid;  // one received byte this cycle
  logic [7:0] char_data;   // received byte
  rcf_mode_e  mode;        // current reset-response mode
  logic       party;       // party addressing selected
  logic       addressed;   // this unit addressed in party mode
  logic       reset_req;   // detector asks for a soft reset

  modport ctl (output char_valid, char_data, mode, party, addressed,
               input reset_req);
  modport det (input char_valid, char_data, mode, party, addressed,
               output reset_req);
endinterface : rcf_char_if

//--- rcf_ctrlc_det.sv
// ctrl-c detector deciding whether a soft reset is due
`include "rcf_cfg.svh"
module rcf_ctrlc_det
  import rcf_pkg::*;
(
  input  wire logic sys_clk_in,   // system clock
  input  wire logic reset_n_in,   // async reset, active low
  rcf_char_if.det   char_if       // byte stream and mode in, request out
);

  rcf_det_s st;       // registered state
  rcf_det_s next_st;  // next state
  logic     is_ctrlc; // byte is the control character

  // match the raw byte, regardless of where it sits in a line
  assign is_ctrlc = char_if.char_valid
                    && (char_if.char_data == `RCF_CTRL_C);

  // decide on the request; party addressing only gates mode 2
  always_comb begin
    next_st = st;
    next_st.reset_req = 1'b0;
    if (is_ctrlc) begin
      unique case (char_if.mode)
        RCF_OFF: begin
          next_st.reset_req = 1'b0;
        end
        RCF_ON: begin
          next_st.reset_req = 1'b1;
        end
        RCF_PARTY: begin
          // outside party mode this acts exactly like mode 1
          next_st.reset_req = !char_if.party || char_if.addressed;
        end
        default: begin
          next_st.reset_req = 1'b0; // code 3 can never be stored
        end
      endcase
    end
  end

  // register the state
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign char_if.reset_req = st.reset_req;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_ctrlc;
    char_if.char_valid && char_if.char_data == `RCF_CTRL_C;
  endsequence

  mode0_ignore_a: assert property (
    s_ctrlc ##0 char_if.mode == RCF_OFF |=> !char_if.reset_req)
    else $error("ctrl-c acted on while disabled");
  mode1_reset_a: assert property (
    s_ctrlc ##0 char_if.mode == RCF_ON |=> char_if.reset_req)
    else $error("ctrl-c did not request reset in mode 1");
  party_gate_a: assert property (
    s_ctrlc ##0 char_if.mode == RCF_PARTY
      |=> char_if.reset_req == ($past(!char_if.party)
                                || $past(char_if.addressed)))
    else $error("party gating of ctrl-c wrong");
  ctrlc_code_a: assert property (
    char_if.reset_req |-> $past(char_if.char_valid)
      && $past(char_if.char_data) == `RCF_CTRL_C)
    else $error("reset requested without a ctrl-c byte");

endmodule : rcf_ctrlc_det

//--- rcf_host_model.sv
// host terminal model: serial bytes and register commands
module rcf_host_model (
  input  wire logic        clk_in,        // system clock
  output logic             rx_valid_out,  // byte strobe
  output logic      [7:0]  rx_data_out,   // byte
  output logic             reg_wr_out,    // assignment
  output logic             reg_rd_out,    // print query
  output logic      [15:0] reg_addr_out,  // offset
  output logic      [31:0] reg_wdata_out, // value
  input  wire logic        reg_ack_in,    // answer
  input  wire logic [31:0] reg_rdata_in,  // value back
  input  wire logic        range_err_in   // refused
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle at time zero, nothing asked before reset ends
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 16'h0000;
    reg_wdata_out = 32'h0;
  end
  // one byte, no line framing around it
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_data_out = b;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~b;  // stale byte must not pass for a new one
  endtask
  // one-cycle strobe; the answer stands one cycle only
  task automatic access(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic k, output logic [31:0] q,
      output logic e);
    @(negedge clk_in);
    reg_wr_out = w;
    reg_rd_out = ~w;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(negedge clk_in);
    // the answer stands in the cycle after the strobe: take it first
    k = reg_ack_in;
    q = reg_rdata_in;
    e = range_err_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
endmodule // rcf_host_model

//--- rcf_reset_char_test.sv
// self-checking bench for the reset-char and rotor-fault block
`include "rcf_cfg.svh"
module rcf_reset_char_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n;       // clock, reset active low
  logic        party, addressed; // party mode, unit named
  logic        lock, mask;       // lock event, attention enable
  logic        rx_v, wr, rd, ack, err, k, e;
  logic [7:0]  rx_d, ecode;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, q;
  logic        srst, stop, halt, drop, flag, attn, bridge;
  logic [11:0] w;                // three samples of reset outputs
  logic [10:0] stat;             // flag, code, attention, stage
  int          n_mismatch, total_checks;
  assign stat = {flag, ecode, attn, bridge};
  // 10 ns period
  always #5 clk = ~clk;

  rcf_reset_char dut (.sys_clk_in(clk), .reset_n_in(rst_n),
    .rx_valid_in(rx_v), .rx_data_in(rx_d),
    .party_addressing_select_in(party), .unit_addressed_in(addressed),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .rotor_lock_detect_in(lock),
    .attention_output_mask_in(mask), .reg_rdata_out(rdata),
    .reg_ack_out(ack), .mode_range_err_out(err),
    .soft_reset_out(srst), .motion_stop_out(stop),
    .program_halt_out(halt), .user_data_discard_out(drop),
    .locked_rotor_flag_out(flag), .error_code_out(ecode),
    .attention_out(attn), .bridge_enable_out(bridge));
  rcf_host_model host (.clk_in(clk), .rx_valid_out(rx_v),
    .rx_data_out(rx_d), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_ack_in(ack),
    .reg_rdata_in(rdata), .range_err_in(err));

  // counts each comparison, reports a miss at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one verdict for the normal end and the watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // mode assignment, answered once
  task automatic set_mode(input logic [1:0] m);
    host.access(1'b1, `RCF_MODE_OFS, {30'h0, m}, k, q, e);
    chk(32'(k), 32'h1);
  endtask
  // pulse must land exactly two cycles after the byte, once
  task automatic ctrlc(input logic [7:0] b, input logic [11:0] exp);
    host.send_byte(b);
    repeat (3) begin
      @(negedge clk);
      w = {w[7:0], srst, stop, halt, drop};
    end
    chk(32'(w), 32'(exp));
  endtask
  // power-up: mode 1, no fault, stage allowed
  task automatic t_reset;
    host.access(1'b0, `RCF_MODE_OFS, 32'h0, k, q, e);
    chk(q, 32'h1);
    chk(32'(stat), 32'h001);
    $display("test reset done");
  endtask
  // ctrl-c in every mode with party mode off, then a near miss byte
  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      set_mode(2'(m));
      ctrlc(`RCF_CTRL_C, (m == 0) ? 12'h000 : 12'hf00);
    end
    ctrlc(8'h83, 12'h000);
    $display("test modes done");
  endtask
  // mode 2 in party mode acts only when this unit is addressed
  task automatic t_party;
    party = 1'b1;
    ctrlc(`RCF_CTRL_C, 12'h000);
    addressed = 1'b1;
    ctrlc(`RCF_CTRL_C, 12'hf00);
    party = 1'b0;
    addressed = 1'b0;
    $display("test party done");
  endtask
  // refused value keeps the mode; unmapped offset reads zero
  task automatic t_range;
    host.access(1'b1, `RCF_MODE_OFS, 32'h3, k, q, e);
    chk(32'({k, e}), 32'h3);
    host.access(1'b0, `RCF_MODE_OFS, 32'h0, k, q, e);
    chk(q, 32'h2);
    host.access(1'b0, 16'h0010, 32'h0, k, q, e);
    chk(q, 32'h0);
    $display("test range done");
  endtask
  // lock with attention enabled, then masked; each cleared by command
  task automatic t_lock;
    for (int i = 1; i >= 0; i--) begin
      mask = 1'(i);
      lock = 1'b1;
      @(negedge clk);
      lock = 1'b0;
      chk(32'(stat), {21'h0, 1'b1, `RCF_ERR_LOCK, 1'(i), 1'b0});
      host.access(1'b1, `RCF_CLEAR_OFS, 32'h0, k, q, e);
      chk(32'(stat), 32'h001);
    end
    $display("test lock done");
  endtask
  // lock beside a clear keeps the fault; power reset restores defaults
  task automatic t_power;
    mask = 1'b0;
    fork
      host.access(1'b1, `RCF_CLEAR_OFS, 32'h0, k, q, e);
      begin
        @(negedge clk);
        lock = 1'b1;
        @(negedge clk);
        lock = 1'b0;
      end
    join
    chk(32'(stat), {21'h0, 1'b1, `RCF_ERR_LOCK, 2'b00});
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(32'(stat), 32'h001);
    host.access(1'b0, `RCF_MODE_OFS, 32'h0, k, q, e);
    chk(q, 32'h1);
    $display("test power done");
  endtask
  // reset for ten cycles, release on a falling edge
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    party = 1'b0;
    addressed = 1'b0;
    lock = 1'b0;
    mask = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_modes;
    t_party;
    t_range;
    t_lock;
    t_power;
    report_and_stop;
  end
  // the run needs some 70 cycles; far beyond that it has hung
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule // rcf_reset_char_test
